// File: lsau_cfg.svh
/*
  Constants for the limit status and alert unit: register offsets, bit positions,
  reset values.
  Assumes inclusion by bare name from the package and the limit_status_alert_unit module.
*/
`ifndef LSAU_CFG_SVH
`define LSAU_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSAU_OFF_STATUS_PRI 8'h41
`define LSAU_OFF_STATUS_SEC 8'h42
`define LSAU_OFF_MASK_PRI 8'h74
`define LSAU_OFF_MASK_SEC 8'h75
`define LSAU_OFF_ALERT_CFG 8'h78

// ----------------------------------------
// primary status / mask bit positions
// ----------------------------------------
`define LSAU_P_SEC_PEND 7
`define LSAU_P_REM2 6
`define LSAU_P_LOCAL 5
`define LSAU_P_REM1 4
`define LSAU_P_MAIN 2
`define LSAU_P_RAIL25 0

// ----------------------------------------
// secondary status / mask bit positions
// ----------------------------------------
`define LSAU_S_DIODE2 7
`define LSAU_S_DIODE1 6
`define LSAU_S_FAN4 5
`define LSAU_S_THIRD_FAN_SLOW 4
`define LSAU_S_SECOND_FAN_SLOW 3
`define LSAU_S_FIRST_FAN_SLOW 2
`define LSAU_S_OVT 1

// ----------------------------------------
// field masks and reset values
// ----------------------------------------
`define LSAU_PRI_SRC_BITS 8'h75
`define LSAU_SEC_SRC_BITS 8'hFE
`define LSAU_ALERT_EN_BIT 0
`define LSAU_RST_STATUS 8'h00
`define LSAU_RST_MASK 8'h00
`define LSAU_RST_ALERT_CFG 8'h00

`endif

// File: lsau_pkg.sv
/*
  Types for the limit status and alert unit.
  Assumes lsau_cfg.svh is on the include path.
*/
`include "lsau_cfg.svh"

package lsau_pkg;

  // ----------------------------------------
  // measured value, limits and valid strobe of one channel
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] highLimit;
    logic [7:0] lowLimit;
    logic       valid;
  } lsau_meas_type;

  // ----------------------------------------
  // raw out-of-limit conditions
  // ----------------------------------------
  typedef struct packed {
    logic diodeTwoFault;
    logic diodeOneFault;
    logic fourthFanOrTimer;
    logic thirdFanSlow;
    logic secondFanSlow;
    logic firstFanSlow;
    logic overtemp;
  } lsau_event_type;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } lsau_req_type;

  typedef enum logic [1:0] {
    LSAU_RD_IDLE = 2'b00,
    LSAU_RD_HOLD = 2'b01,
    LSAU_RD_DONE = 2'b11
  } lsau_rd_state_type;

endpackage

// File: lsau_limit_cmp.sv
/*
  One channel's limit comparator: registered out-of-limit flag.
  Assumes a synchronous active-low reset already released by the parent.
*/
`timescale 1ns/1ns
`default_nettype none

module lsau_limit_cmp (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstSyncN,
  // measurement
  input  wire lsau_pkg::lsau_meas_type meas,
  // result
  output logic                        outOfLimit
);
  import lsau_pkg::*;

  // ----------------------------------------
  // comparison
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      outOfLimit <= 1'b0;
    end else if (meas.valid) begin
      // high limit is strict, low limit includes equality
      outOfLimit <= (meas.value > meas.highLimit) || (meas.value <= meas.lowLimit); // RULE19
    end
  end

  ovl_high_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE19
    meas.valid && meas.value > meas.highLimit |=> outOfLimit)
    else $error("high limit violation missed");
  ovl_equal_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE19
    meas.valid && meas.value == meas.highLimit && meas.value > meas.lowLimit |=> !outOfLimit)
    else $error("equal to high limit flagged");

endmodule

`default_nettype wire

// File: limit_status_alert_unit.sv
/*
  Sticky limit status, alert masks and open-drain alert output of a hardware monitor.
  Assumes a register port already decoded from the serial bus, one request per cycle,
  and measurement engines that present value and limits with a valid strobe.
*/
// Operation
// RULE1 - bit7 primary flags secondary register activity
// RULE2 - primary bits 6,5,4 temperature violations
// RULE3 - primary bit2 main supply, bit0 rail
// RULE4 - secondary bits 7,6 diode faults
// RULE5 - secondary bit5 fan four or timer
// RULE6 - secondary bits 4,3,2 fans three..one
// RULE7 - secondary bit1 overtemperature, bit0 unused
// RULE8 - status set immediately on violation
// RULE9 - clear needs condition gone and read
// RULE10 - alert low while violating until read
// RULE11 - mask gates alert, never status
// RULE12 - mask bit7 blocks all secondary sources
// RULE13 - mask bits 6,5,4 block temperatures
// RULE14 - mask bit2 main, bit0 rail
// RULE15 - mask registers at 0x74 and 0x75
// RULE16 - host masks, polls, then unmasks
// RULE17 - secondary mask bits block matching sources
// RULE18 - alert disabled after reset until enabled
// RULE19 - high strict, low inclusive comparison
// RULE20 - alert on any unmasked set status
`timescale 1ns/1ns
`default_nettype none
`include "lsau_cfg.svh"

module limit_status_alert_unit (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // register port
  input  wire lsau_pkg::lsau_req_type  req,
  output logic [7:0]                   rdData,
  output logic                         rdValid,
  // analog channels
  input  wire lsau_pkg::lsau_meas_type remoteTwoMeas,
  input  wire lsau_pkg::lsau_meas_type localMeas,
  input  wire lsau_pkg::lsau_meas_type remoteOneMeas,
  input  wire lsau_pkg::lsau_meas_type mainSupplyMeas,
  input  wire lsau_pkg::lsau_meas_type railMeas,
  // digital events
  input  wire lsau_pkg::lsau_event_type events,
  // open-drain alert pin
  input  wire logic                    alertIn,
  output logic                         alertOut,
  output logic                         alertOe
);
  import lsau_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rstMeta;
  logic rstSyncN;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // ----------------------------------------
  // comparators
  // ----------------------------------------
  logic remoteTwoOol;
  logic localOol;
  logic remoteOneOol;
  logic mainSupplyOol;
  logic railOol;

  lsau_limit_cmp cmpRemoteTwo (.clock(clock), .rstSyncN(rstSyncN), .meas(remoteTwoMeas),
    .outOfLimit(remoteTwoOol));
  lsau_limit_cmp cmpLocal (.clock(clock), .rstSyncN(rstSyncN), .meas(localMeas),
    .outOfLimit(localOol));
  lsau_limit_cmp cmpRemoteOne (.clock(clock), .rstSyncN(rstSyncN), .meas(remoteOneMeas),
    .outOfLimit(remoteOneOol));
  lsau_limit_cmp cmpMain (.clock(clock), .rstSyncN(rstSyncN), .meas(mainSupplyMeas),
    .outOfLimit(mainSupplyOol));
  lsau_limit_cmp cmpRail (.clock(clock), .rstSyncN(rstSyncN), .meas(railMeas),
    .outOfLimit(railOol));

  // ----------------------------------------
  // live condition vectors
  // ----------------------------------------
  logic [7:0] priCond;
  logic [7:0] secCond;

  always_comb begin
    priCond = 8'h00;
    priCond[`LSAU_P_REM2]   = remoteTwoOol;  // RULE2
    priCond[`LSAU_P_LOCAL]  = localOol;      // RULE2
    priCond[`LSAU_P_REM1]   = remoteOneOol;  // RULE2
    priCond[`LSAU_P_MAIN]   = mainSupplyOol; // RULE3
    priCond[`LSAU_P_RAIL25] = railOol;       // RULE3
    secCond = 8'h00;
    secCond[`LSAU_S_DIODE2] = events.diodeTwoFault;    // RULE4
    secCond[`LSAU_S_DIODE1] = events.diodeOneFault;    // RULE4
    secCond[`LSAU_S_FAN4]   = events.fourthFanOrTimer; // RULE5
    secCond[`LSAU_S_THIRD_FAN_SLOW]   = events.thirdFanSlow;     // RULE6
    secCond[`LSAU_S_SECOND_FAN_SLOW]   = events.secondFanSlow;    // RULE6
    secCond[`LSAU_S_FIRST_FAN_SLOW]   = events.firstFanSlow;     // RULE6
    secCond[`LSAU_S_OVT]    = events.overtemp;         // RULE7
  end

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic logic hit(input lsau_req_type r, input logic [7:0] off);
    hit = r.addr == off;
  endfunction

  logic rdPri;
  logic rdSec;
  assign rdPri = req.rdEn && hit(req, `LSAU_OFF_STATUS_PRI);
  assign rdSec = req.rdEn && hit(req, `LSAU_OFF_STATUS_SEC);

  // ----------------------------------------
  // sticky status
  // ----------------------------------------
  // a bit clears on a read only where its condition is already gone;
  // a live condition always re-sets, so set wins over clear
  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] cond,
                                        input logic rd, input logic [7:0] keep);
    sticky = ((rd ? (cur & cond) : cur) | cond) & keep;
  endfunction

  logic [7:0] secStatus_q;
  logic [7:0] priStatus_q;

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      secStatus_q <= `LSAU_RST_STATUS;
    end else begin
      secStatus_q <= sticky(secStatus_q, secCond, rdSec, `LSAU_SEC_SRC_BITS); // RULE8 RULE9
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      priStatus_q <= `LSAU_RST_STATUS;
    end else begin
      priStatus_q <= sticky(priStatus_q, priCond, rdPri, `LSAU_PRI_SRC_BITS); // RULE8 RULE9
    end
  end

  // summary follows the secondary register itself
  logic [7:0] priView;
  always_comb begin
    priView = priStatus_q;
    priView[`LSAU_P_SEC_PEND] = |secStatus_q; // RULE1
  end

  // ----------------------------------------
  // mask and alert configuration registers
  // ----------------------------------------
  logic [7:0] priMask_q;
  logic [7:0] secMask_q;
  logic       alertEn_q;

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      priMask_q <= `LSAU_RST_MASK;
      secMask_q <= `LSAU_RST_MASK;
    end else if (req.wrEn) begin
      if (hit(req, `LSAU_OFF_MASK_PRI)) begin // RULE15
        priMask_q <= req.wrData & (`LSAU_PRI_SRC_BITS | 8'h80);
      end
      if (hit(req, `LSAU_OFF_MASK_SEC)) begin // RULE15
        secMask_q <= req.wrData & `LSAU_SEC_SRC_BITS;
      end
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      alertEn_q <= 1'b0; // RULE18
    end else if (req.wrEn && hit(req, `LSAU_OFF_ALERT_CFG)) begin
      alertEn_q <= req.wrData[`LSAU_ALERT_EN_BIT];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    case (req.addr)
      `LSAU_OFF_STATUS_PRI: rdMux = priView;
      `LSAU_OFF_STATUS_SEC: rdMux = secStatus_q;
      `LSAU_OFF_MASK_PRI:   rdMux = priMask_q;
      `LSAU_OFF_MASK_SEC:   rdMux = secMask_q;
      `LSAU_OFF_ALERT_CFG:  rdMux = {7'h00, alertEn_q};
      default:              rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rdData  <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdValid <= req.rdEn;
      if (req.rdEn) begin
        rdData <= rdMux;
      end
    end
  end

  // ----------------------------------------
  // alert generation
  // ----------------------------------------
  logic priAlert;
  logic secAlert;
  logic alertReq;

  // mask gates only the alert path; status above never sees it
  assign secAlert = |(secStatus_q & ~secMask_q) && !priMask_q[`LSAU_P_SEC_PEND]; // RULE12 RULE17
  assign priAlert = |(priStatus_q & ~priMask_q & `LSAU_PRI_SRC_BITS); // RULE11 RULE13 RULE14
  assign alertReq = alertEn_q && (priAlert || secAlert); // RULE20 RULE10

  // open drain: enable pulls the wire low, output data is always zero
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      alertOe  <= 1'b0;
      alertOut <= 1'b0;
    end else begin
      alertOe  <= alertReq; // RULE10
      alertOut <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence condHeld(c);
    c ##1 c;
  endsequence

  stat_sets_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE8
    secCond[`LSAU_S_FIRST_FAN_SLOW] |=> secStatus_q[`LSAU_S_FIRST_FAN_SLOW])
    else $error("status not set on violation");
  read_live_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE9
    rdPri ##0 condHeld(priCond[`LSAU_P_REM1]) |-> priStatus_q[`LSAU_P_REM1])
    else $error("read cleared live condition");
  sticky_hold_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE9
    secStatus_q[`LSAU_S_OVT] && !rdSec |=> secStatus_q[`LSAU_S_OVT])
    else $error("status bit dropped without read");
  read_clear_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE9
    rdPri && !priCond[`LSAU_P_MAIN] |=> !priStatus_q[`LSAU_P_MAIN])
    else $error("read did not clear idle bit");
  summary_bit_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE1
    priView[`LSAU_P_SEC_PEND] == (secStatus_q != 8'h00))
    else $error("summary bit mismatch");
  mask_status_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE11
    priMask_q[`LSAU_P_LOCAL] && priCond[`LSAU_P_LOCAL] |=> priStatus_q[`LSAU_P_LOCAL])
    else $error("masked source lost status");
  sec_block_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE12
    priMask_q[`LSAU_P_SEC_PEND] && !priAlert |=> !alertOe)
    else $error("secondary alert not blocked");
  alert_drive_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE10
    alertEn_q && priStatus_q[`LSAU_P_RAIL25] && !priMask_q[`LSAU_P_RAIL25] |=> alertOe)
    else $error("alert not driven");
  alert_off_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE18
    !alertEn_q |=> !alertOe)
    else $error("alert driven while disabled");
  fan_mask_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE17
    secStatus_q == 8'h20 && secMask_q[`LSAU_S_FAN4] && !priAlert |=> !alertOe)
    else $error("fan four mask ignored");
  mask_write_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE15
    req.wrEn && req.addr == `LSAU_OFF_MASK_SEC |=> secMask_q == ($past(req.wrData) & 8'hFE))
    else $error("secondary mask write lost");
  pri_mask_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE15 RULE13
    req.wrEn && req.addr == `LSAU_OFF_MASK_PRI |=> priMask_q == ($past(req.wrData) & 8'hF5))
    else $error("primary mask write lost");

  // live overtemperature, then an open path to the pin
  sequence ovtRaised;
    secCond[`LSAU_S_OVT] ##1
      (alertEn_q && !priMask_q[`LSAU_P_SEC_PEND] && !secMask_q[`LSAU_S_OVT]);
  endsequence

  ovt_alert_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE7 RULE20
    ovtRaised |=> alertOe)
    else $error("overtemperature alert missed");
  diode_sets_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE4
    events.diodeTwoFault |=> secStatus_q[`LSAU_S_DIODE2])
    else $error("diode fault status missed");
  temp_sets_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE2
    remoteTwoOol |=> priStatus_q[`LSAU_P_REM2])
    else $error("remote temperature status missed");
  supply_sets_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE3
    mainSupplyOol |=> priStatus_q[`LSAU_P_MAIN])
    else $error("main supply status missed");
  fan_alert_a: assert property (@(posedge clock) disable iff (!rstSyncN) // RULE6 RULE10
    alertEn_q && secStatus_q[`LSAU_S_THIRD_FAN_SLOW] && !secMask_q[`LSAU_S_THIRD_FAN_SLOW]
      && !priMask_q[`LSAU_P_SEC_PEND] |=> alertOe)
    else $error("fan three alert missed");

endmodule

`default_nettype wire

// File: lsau_host_model.sv
/*
  Host side of the alert line: pull-up wire and interrupt sense.
  Assumes the unit pulls the line low while its output enable is high.
*/
`timescale 1ns/1ns
`default_nettype none

module lsau_host_model (
  // unit side
  input  wire logic alertOe,
  input  wire logic alertOut,
  // host side
  output logic      alertLine,
  output logic      alertSeen
);
  // released line floats to the pull-up level
  assign alertLine = alertOe ? alertOut : 1'b1;
  assign alertSeen = ~alertLine;
endmodule

`default_nettype wire

// File: limit_status_alert_unit_tb_top.sv
/*
  Self-checking bench of the limit status and alert unit.
  Assumes the design package and lsau_cfg.svh are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module limit_status_alert_unit_tb_top;
  import lsau_pkg::*;

  logic           clock = 1'b0;
  logic           rstn = 1'b0;
  lsau_req_type   req;
  logic [7:0]     rdData;
  logic           rdValid;
  logic           alertOut;
  logic           alertOe;
  logic           alertLine;
  logic           alertSeen;
  lsau_meas_type  meas [5];
  lsau_event_type events;
  int             errors = 0;
  int             compares = 0;
  int             seed;
  logic [7:0]     d;
  logic [7:0]     v;
  logic [7:0]     h;
  logic [7:0]     l;
  logic [6:0]     e;
  logic           ex;
  // status bit of each analog channel, in port order
  int             chBit [5] = '{6, 5, 4, 2, 0};

  always #10 clock = ~clock;

  limit_status_alert_unit DUT (
    .clock(clock), .rstn(rstn), .req(req), .rdData(rdData), .rdValid(rdValid),
    .remoteTwoMeas(meas[0]), .localMeas(meas[1]), .remoteOneMeas(meas[2]),
    .mainSupplyMeas(meas[3]), .railMeas(meas[4]), .events(events),
    .alertIn(alertLine), .alertOut(alertOut), .alertOe(alertOe)
  );

  lsau_host_model host (
    .alertOe(alertOe), .alertOut(alertOut), .alertLine(alertLine), .alertSeen(alertSeen)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  // high limit strict, low limit inclusive
  function automatic logic exp_ool(input logic [7:0] mv, input logic [7:0] mh,
                                   input logic [7:0] ml);
    exp_ool = (mv > mh) || (mv <= ml);
  endfunction

  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(negedge clock);
    req = '{1'b1, 1'b0, a, x};
    @(negedge clock);
    req.wrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(negedge clock);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    req.rdEn = 1'b0;
    // answer is due one cycle after the strobe; a stuck port ends the run
    while (rdValid !== 1'b1 && n < 3) begin
      @(negedge clock);
      n++;
    end
    if (n == 3) begin
      errors++;
      give_verdict();
    end
    d = rdData;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    rd(a);
    chk(d, x);
  endtask

  task automatic mp(input int c, input logic [7:0] mv, input logic [7:0] mh,
                    input logic [7:0] ml);
    @(negedge clock);
    meas[c] = '{mv, mh, ml, 1'b1};
    @(negedge clock);
    meas[c].valid = 1'b0;
    w(3);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    req = '0;
    events = '0;
    foreach (meas[i]) meas[i] = '0;
    seed = 32'h2F59;
    w(8);
    rstn = 1'b1;
    w(4);
    rchk(8'h41, 8'h00);
    rchk(8'h42, 8'h00);
    rchk(8'h74, 8'h00);
    rchk(8'h75, 8'h00);
    rchk(8'h78, 8'h00);
    rchk(8'h10, 8'h00);
    repeat (4) begin
      v = 8'($random(seed));
      wr(8'h74, v);
      rchk(8'h74, v & 8'hF5);
      wr(8'h75, v);
      rchk(8'h75, v & 8'hFE);
    end
    wr(8'h74, 8'h00);
    wr(8'h75, 8'h00);
    // alert stays off while the output function is disabled
    events.overtemp = 1'b1;
    w(3);
    chk(alertOe, 1'b0);
    events = '0;
    rd(8'h42);
    wr(8'h78, 8'h01);
    $display("test reset and masks done");

    for (int i = 0; i < 7; i++) begin
      e = 7'h01 << i;
      events = e;
      w(3);
      chk(alertOe, 1'b1);
      chk(alertLine, 1'b0);
      chk(alertSeen, 1'b1);
      rchk(8'h42, {e, 1'b0});
      rchk(8'h41, 8'h80);
      rchk(8'h42, {e, 1'b0});
      events = '0;
      w(2);
      chk(alertOe, 1'b1);
      rchk(8'h42, {e, 1'b0});
      rchk(8'h42, 8'h00);
      w(2);
      chk(alertOe, 1'b0);
      rchk(8'h41, 8'h00);
    end
    $display("test events done");

    // host masks the source, unmasks it while status is still set, then blocks it with mask bit7
    wr(8'h75, 8'h02);
    events.overtemp = 1'b1;
    w(3);
    chk(alertOe, 1'b0);
    rchk(8'h42, 8'h02);
    wr(8'h75, 8'h00);
    w(2);
    chk(alertOe, 1'b1);
    wr(8'h74, 8'h80);
    w(2);
    chk(alertOe, 1'b0);
    wr(8'h74, 8'h00);
    events = '0;
    rd(8'h42);
    w(2);
    chk(alertOe, 1'b0);
    // fan four source masked on its own
    wr(8'h75, 8'h20);
    events.fourthFanOrTimer = 1'b1;
    w(3);
    chk(alertOe, 1'b0);
    rchk(8'h42, 8'h20);
    events = '0;
    rd(8'h42);
    wr(8'h75, 8'h00);
    w(2);
    chk(alertOe, 1'b0);
    $display("test secondary masking done");

    for (int c = 0; c < 5; c++) begin
      for (int k = 0; k < 8; k++) begin
        h = 8'h40;
        l = 8'h10;
        // edges of both limits first, then random triples
        case (k)
          0: v = 8'h40;
          1: v = 8'h41;
          2: v = 8'h10;
          3: v = 8'h11;
          default: begin
            v = 8'($random(seed));
            h = 8'($random(seed));
            l = 8'($random(seed));
          end
        endcase
        ex = exp_ool(v, h, l);
        mp(c, v, h, l);
        rchk(8'h41, {7'h00, ex} << chBit[c]);
        chk(alertOe, ex);
        wr(8'h74, 8'h01 << chBit[c]);
        w(2);
        chk(alertOe, 1'b0);
        rchk(8'h41, {7'h00, ex} << chBit[c]);
        wr(8'h74, 8'h00);
        mp(c, 8'h80, 8'hFF, 8'h00);
        rd(8'h41);
        rchk(8'h41, 8'h00);
      end
    end
    $display("test analog channels done");
    give_verdict();
  end
endmodule

`default_nettype wire
